// [src/mis_exec.sv]
`timescale 1ns/100ps
`include "mis_consts.svh"
module mis_exec (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             clk_en,
  input  wire logic             issue_valid,
  input  wire mis_pkg::mis_op_e issue_op,
  input  wire logic             issue_dest,
  input  wire logic [5:0]       issue_addr,
  input  wire logic [7:0]       issue_imm,
  input  wire logic [3:0]       issue_sfr,
  input  wire logic [7:0]       accumulator,
  input  wire logic [7:0]       reg_rdata,
  input  wire logic [7:0]       sfr_rdata,
  output logic                  acc_wr,
  output logic [7:0]            acc_wdata,
  output logic                  reg_wr,
  output logic [5:0]            reg_waddr,
  output logic [7:0]            reg_wdata,
  output logic                  z_wr,
  output logic                  z_val,
  output logic                  discard_fetch,
  output logic                  stall,
  output logic                  done
);
  mis_pkg::mis_state_s q;
  mis_pkg::mis_state_s next_q;
  logic                issue_ok;

  mis_alu_if alu_bus();

  assign alu_bus.op       = issue_op;
  assign alu_bus.dest     = issue_dest;
  assign alu_bus.acc      = accumulator;
  assign alu_bus.reg_data = reg_rdata;
  assign alu_bus.imm      = issue_imm;
  assign alu_bus.sfr_idx  = issue_sfr;
  assign alu_bus.sfr_data = sfr_rdata;

  mis_alu u_alu (
    .bus (alu_bus.alu)
  );

  // requests are refused while the no-op slot of a skip runs
  assign issue_ok = issue_valid && !q.stall;

  always_comb begin
    next_q         = q;
    next_q.acc_wr  = 1'b0;
    next_q.reg_wr  = 1'b0;
    next_q.z_wr    = 1'b0;
    next_q.discard = 1'b0;
    next_q.done    = 1'b0;
    unique case (q.st)
      mis_pkg::MIS_ST_RUN: begin
        if (issue_ok && alu_bus.res.legal) begin
          next_q.acc_wr    = alu_bus.res.acc_wr;
          next_q.acc_wdata = alu_bus.res.result;
          next_q.reg_wr    = alu_bus.res.reg_wr;
          next_q.reg_waddr = issue_addr;
          next_q.reg_wdata = alu_bus.res.result;
          next_q.z_wr      = alu_bus.res.z_wr;
          next_q.z_val     = (alu_bus.res.result == `MIS_ZERO);
          if (alu_bus.res.skip) begin
            // prefetched word is thrown away; its slot becomes a no-op
            next_q.discard = 1'b1;
            next_q.stall   = 1'b1;
            next_q.st      = mis_pkg::MIS_ST_SKIP;
          end else begin
            next_q.done    = 1'b1;
          end
        end else if (issue_ok) begin
          next_q.done = 1'b1;
        end
      end
      mis_pkg::MIS_ST_SKIP: begin
        next_q.stall = 1'b0;
        next_q.done  = 1'b1;
        next_q.st    = mis_pkg::MIS_ST_RUN;
      end
    endcase
  end

  // reset clears stall too, so a skip cut short leaves no dead slot behind
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else if (clk_en) begin
      q <= next_q;
    end
  end

  assign acc_wr        = q.acc_wr;
  assign acc_wdata     = q.acc_wdata;
  assign reg_wr        = q.reg_wr;
  assign reg_waddr     = q.reg_waddr;
  assign reg_wdata     = q.reg_wdata;
  assign z_wr          = q.z_wr;
  assign z_val         = q.z_val;
  assign discard_fetch = q.discard;
  assign stall         = q.stall;
  assign done          = q.done;

  // checks: each issue is sampled with clk_en high and the following
  // cycle also enabled, so the outputs have really advanced
  sequence s_incr(logic zero);
    clk_en && issue_ok && issue_op == mis_pkg::increment_skip_zero_op &&
    ((reg_rdata == 8'hFF) == zero) ##1 clk_en;
  endsequence

  sequence s_or_reg;
    clk_en && issue_ok && issue_op == mis_pkg::or_acc_with_reg_op ##1 clk_en;
  endsequence

  sequence s_or_imm;
    clk_en && issue_ok && issue_op == mis_pkg::or_immediate_acc_op
    ##1 clk_en;
  endsequence

  sequence s_sfr;
    clk_en && issue_ok && issue_op == mis_pkg::read_page2_sfr_op &&
    issue_sfr >= 4'h5 ##1 clk_en;
  endsequence

  sequence s_sfr_bad;
    clk_en && issue_ok && issue_op == mis_pkg::read_page2_sfr_op &&
    issue_sfr < `MIS_SFR_MIN ##1 clk_en;
  endsequence

  sequence s_none;
    clk_en && issue_ok && issue_op == mis_pkg::MIS_OP_NONE ##1 clk_en;
  endsequence

  // the no-op slot: prefetched word dropped, then done with no writes
  sequence s_skip_slot;
    (discard_fetch && stall && !done) ##1
    (done && !stall && !acc_wr && !reg_wr && !z_wr && !discard_fetch);
  endsequence

  incr_dest_write_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    s_incr(1'b0) |->
      (acc_wr == !$past(issue_dest)) && (reg_wr == $past(issue_dest)) &&
      (reg_wdata == 8'($past(reg_rdata) + 8'h01)) &&
      (reg_waddr == $past(issue_addr)) && !z_wr)
    else $error("increment write wrong");

  skip_two_cycle_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    s_incr(1'b1) |-> s_skip_slot)
    else $error("skip sequence wrong");

  no_skip_one_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    s_incr(1'b0) |-> done && !discard_fetch && !stall)
    else $error("non-skip increment not single cycle");

  or_reg_result_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    s_or_reg |->
      done && z_wr && !discard_fetch &&
      (acc_wdata == ($past(accumulator) | $past(reg_rdata))) &&
      (!reg_wr || reg_wdata == ($past(accumulator) | $past(reg_rdata))) &&
      (!reg_wr || reg_waddr == $past(issue_addr)) &&
      (z_val == (($past(accumulator) | $past(reg_rdata)) == 8'h00)) &&
      (acc_wr == !$past(issue_dest)) && (reg_wr == $past(issue_dest)))
    else $error("register or wrong");

  or_imm_result_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    s_or_imm |->
      done && acc_wr && z_wr && !reg_wr &&
      (z_val == (($past(accumulator) | $past(issue_imm)) == 8'h00)) &&
      (acc_wdata == ($past(accumulator) | $past(issue_imm))))
    else $error("immediate or wrong");

  sfr_read_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    s_sfr |->
      done && acc_wr && !z_wr && !reg_wr &&
      (acc_wdata == $past(sfr_rdata)))
    else $error("page-2 read wrong");

  wrap_zero_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    s_incr(1'b1) |->
      (acc_wdata == 8'h00) && discard_fetch &&
      (!reg_wr || reg_wdata == 8'h00))
    else $error("increment did not wrap");

  stall_refuse_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    clk_en && stall |=> !acc_wr && !reg_wr && !z_wr && !discard_fetch)
    else $error("issue taken during skip slot");

  stall_one_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    clk_en && stall |=> !stall)
    else $error("no-op slot longer than one cycle");

  sfr_refuse_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    s_sfr_bad |-> done && !acc_wr && !reg_wr && !z_wr && !discard_fetch)
    else $error("page-2 read below floor wrote");

  none_op_done_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    s_none |-> done && !acc_wr && !reg_wr && !z_wr && !discard_fetch)
    else $error("empty issue wrote");

  idle_quiet_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    clk_en && !issue_valid && !stall |=>
      !acc_wr && !reg_wr && !z_wr && !discard_fetch && !done)
    else $error("output pulse without an issue");

  // no disable clause: this one watches the outputs while reset is held
  reset_clear_a: assert property (
    @(posedge ref_clk)
    !rst_b && !$past(rst_b) |->
      !acc_wr && !reg_wr && !z_wr && !discard_fetch && !stall && !done)
    else $error("outputs not cleared in reset");

  freeze_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !clk_en |=> $stable(q))
    else $error("state moved with clock enable low");
endmodule // mis_exec

// [src/mis_consts.svh]
// Operation
// - increment-skip adds one to data byte 0..63 and writes it to the accumulator when dest is 0, else back to the byte.
// - an increment-skip result of zero discards the prefetched instruction, runs a no-op in its place and takes two cycles, otherwise one.
// - register-or ORs accumulator with the data byte, writes accumulator (dest 0) or byte (dest 1), updates zero, one cycle.
// - immediate-or ORs accumulator with the 8-bit constant of the word, writes accumulator, updates zero, one cycle.
// - page-2 read copies special register 5..15 to the accumulator in one cycle, flags and source untouched.
`ifndef MIS_CONSTS_SVH
`define MIS_CONSTS_SVH
`define MIS_DATA_W      8
`define MIS_ADDR_W      6
`define MIS_SFR_W       4
`define MIS_ADDR_MAX    6'h3F
`define MIS_SFR_MIN     4'h5
`define MIS_SFR_MAX     4'hF
`define MIS_INCR_STEP   8'h01
`define MIS_ZERO        8'h00
`define MIS_DEST_ACC    1'b0
`define MIS_DEST_REG    1'b1
`define MIS_SKIP_CYCLES 2
`define MIS_ONE_CYCLES  1
`endif

// [src/mis_pkg.sv]
package mis_pkg;
  typedef enum logic [2:0] {
    MIS_OP_NONE            = 3'b000,
    increment_skip_zero_op = 3'b001,
    or_acc_with_reg_op     = 3'b010,
    or_immediate_acc_op    = 3'b011,
    read_page2_sfr_op      = 3'b100
  } mis_op_e;

  typedef enum logic {
    MIS_ST_RUN  = 1'b0,
    MIS_ST_SKIP = 1'b1
  } mis_state_e;

  typedef struct packed {
    mis_state_e  st;
    logic        acc_wr;
    logic [7:0]  acc_wdata;
    logic        reg_wr;
    logic [5:0]  reg_waddr;
    logic [7:0]  reg_wdata;
    logic        z_wr;
    logic        z_val;
    logic        discard;
    logic        stall;
    logic        done;
  } mis_state_s;

  typedef struct packed {
    logic        acc_wr;
    logic        reg_wr;
    logic        z_wr;
    logic        skip;
    logic        legal;
    logic [7:0]  result;
  } mis_res_s;
endpackage

// [src/mis_alu_if.sv]
`timescale 1ns/100ps
interface mis_alu_if;
  mis_pkg::mis_op_e  op;
  logic              dest;
  logic [7:0]        acc;
  logic [7:0]        reg_data;
  logic [7:0]        imm;
  logic [3:0]        sfr_idx;
  logic [7:0]        sfr_data;
  mis_pkg::mis_res_s res;

  modport core (output op, dest, acc, reg_data, imm, sfr_idx, sfr_data,
                input res);
  modport alu (input op, dest, acc, reg_data, imm, sfr_idx, sfr_data,
               output res);
endinterface

// [src/mis_alu.sv]
`timescale 1ns/100ps
`include "mis_consts.svh"
module mis_alu (
  mis_alu_if.alu bus
);
  function automatic logic [7:0] or8(input logic [7:0] a,
                                     input logic [7:0] b);
    or8 = a | b;
  endfunction

  logic [7:0] incr;

  // plain 8-bit add drops the carry, so 0xFF wraps to 0x00
  assign incr = bus.reg_data + `MIS_INCR_STEP;

  always_comb begin
    bus.res = '0;
    unique case (bus.op)
      mis_pkg::increment_skip_zero_op: begin
        bus.res.legal  = 1'b1;
        bus.res.result = incr;
        bus.res.acc_wr = (bus.dest == `MIS_DEST_ACC);
        bus.res.reg_wr = (bus.dest == `MIS_DEST_REG);
        bus.res.skip   = (incr == `MIS_ZERO);
      end
      mis_pkg::or_acc_with_reg_op: begin
        bus.res.legal  = 1'b1;
        bus.res.result = or8(bus.acc, bus.reg_data);
        bus.res.acc_wr = (bus.dest == `MIS_DEST_ACC);
        bus.res.reg_wr = (bus.dest == `MIS_DEST_REG);
        bus.res.z_wr   = 1'b1;
      end
      mis_pkg::or_immediate_acc_op: begin
        bus.res.legal  = 1'b1;
        bus.res.result = or8(bus.acc, bus.imm);
        bus.res.acc_wr = 1'b1;
        bus.res.z_wr   = 1'b1;
      end
      mis_pkg::read_page2_sfr_op: begin
        // indexes below the page floor are not readable; treated as no-op
        bus.res.legal  = (bus.sfr_idx >= `MIS_SFR_MIN);
        bus.res.result = bus.sfr_data;
        bus.res.acc_wr = bus.res.legal;
      end
      default: begin
        bus.res = '0;
      end
    endcase
  end
endmodule // mis_alu

// [dv/mcu_incr_skip_or_sfr_read_ops_tb_top.sv]
`timescale 1ns/100ps
module mcu_incr_skip_or_sfr_read_ops_tb_top;
  typedef struct packed {
    mis_pkg::mis_op_e op;
    logic             d;
    logic [5:0]       a;
    logic [7:0]       im;
    logic [3:0]       sf;
    logic [7:0]       ac;
    logic [7:0]       rd;
    logic [7:0]       sd;
    logic [3:0]       wr;
    logic [7:0]       res;
  } mis_row_s;

  localparam mis_pkg::mis_op_e op_inc = mis_pkg::increment_skip_zero_op;
  localparam mis_pkg::mis_op_e op_orr = mis_pkg::or_acc_with_reg_op;
  localparam mis_pkg::mis_op_e op_ori = mis_pkg::or_immediate_acc_op;
  localparam mis_pkg::mis_op_e op_rd  = mis_pkg::read_page2_sfr_op;
  localparam mis_pkg::mis_op_e op_non = mis_pkg::MIS_OP_NONE;

  logic             ref_clk;
  logic             rst_b;
  logic             clk_en;
  logic             issue_valid;
  logic             issue_dest;
  mis_pkg::mis_op_e issue_op;
  logic [5:0]       issue_addr;
  logic [7:0]       issue_imm;
  logic [3:0]       issue_sfr;
  logic [7:0]       accumulator;
  logic [7:0]       reg_rdata;
  logic [7:0]       sfr_rdata;
  logic             acc_wr;
  logic [7:0]       acc_wdata;
  logic             reg_wr;
  logic [5:0]       reg_waddr;
  logic [7:0]       reg_wdata;
  logic             z_wr;
  logic             z_val;
  logic             discard_fetch;
  logic             stall;
  logic             done;
  logic [7:0]       flags;
  int               failures;
  int               checks;
  mis_row_s         rows [10];

  // wr column: acc_wr reg_wr z_wr z_val
  initial begin
    rows = '{
      '{op_inc, 1'h0, 6'h00, 8'h00, 4'h0, 8'h00, 8'h41, 8'h00, 4'h8, 8'h42},
      '{op_inc, 1'h1, 6'h3F, 8'h00, 4'h0, 8'h00, 8'h7F, 8'h00, 4'h4, 8'h80},
      '{op_orr, 1'h0, 6'h05, 8'h00, 4'h0, 8'hAA, 8'h50, 8'h00, 4'hA, 8'hFA},
      '{op_orr, 1'h1, 6'h11, 8'h00, 4'h0, 8'h00, 8'h00, 8'h00, 4'h7, 8'h00},
      '{op_ori, 1'h1, 6'h00, 8'h50, 4'h0, 8'hAA, 8'h0F, 8'h00, 4'hA, 8'hFA},
      '{op_ori, 1'h0, 6'h00, 8'h00, 4'h0, 8'h00, 8'hFF, 8'h00, 4'hB, 8'h00},
      '{op_rd,  1'h0, 6'h00, 8'h00, 4'h5, 8'hAA, 8'h00, 8'h55, 4'h8, 8'h55},
      '{op_rd,  1'h0, 6'h00, 8'h00, 4'hF, 8'hAA, 8'hFF, 8'h00, 4'h8, 8'h00},
      '{op_rd,  1'h0, 6'h00, 8'h00, 4'h4, 8'hAA, 8'h00, 8'h33, 4'h0, 8'h00},
      '{op_non, 1'h0, 6'h00, 8'h00, 4'h0, 8'h00, 8'h00, 8'h00, 4'h0, 8'h00}
    };
  end

  assign flags = {2'h0, acc_wr, reg_wr, z_wr, discard_fetch, stall, done};

  mis_exec uut (
    .ref_clk       (ref_clk),
    .rst_b         (rst_b),
    .clk_en        (clk_en),
    .issue_valid   (issue_valid),
    .issue_op      (issue_op),
    .issue_dest    (issue_dest),
    .issue_addr    (issue_addr),
    .issue_imm     (issue_imm),
    .issue_sfr     (issue_sfr),
    .accumulator   (accumulator),
    .reg_rdata     (reg_rdata),
    .sfr_rdata     (sfr_rdata),
    .acc_wr        (acc_wr),
    .acc_wdata     (acc_wdata),
    .reg_wr        (reg_wr),
    .reg_waddr     (reg_waddr),
    .reg_wdata     (reg_wdata),
    .z_wr          (z_wr),
    .z_val         (z_val),
    .discard_fetch (discard_fetch),
    .stall         (stall),
    .done          (done)
  );

  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // valid stays high on return so back-to-back rows never double-drive it
  task automatic issue(input mis_row_s r);
    issue_valid = 1'h1;
    issue_op    = r.op;
    issue_dest  = r.d;
    issue_addr  = r.a;
    issue_imm   = r.im;
    issue_sfr   = r.sf;
    accumulator = r.ac;
    reg_rdata   = r.rd;
    sfr_rdata   = r.sd;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic idle();
    issue_valid = 1'h0;
    issue_op    = mis_pkg::MIS_OP_NONE;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #(2000 * 100);
    failures++;
    print_verdict();
  end

  initial begin
    failures = 0;
    checks   = 0;
    rst_b    = 1'h0;
    clk_en   = 1'h1;
    // inputs held at a known idle word while reset is low
    issue('{op_non, 1'h0, 6'h00, 8'h00, 4'h0, 8'h00, 8'h00, 8'h00, 4'h0,
            8'h00});
    issue_valid = 1'h0;
    repeat (7) @(posedge ref_clk);
    #1;
    check8(flags, 8'h00);
    check8(acc_wdata, 8'h00);
    check8(reg_wdata, 8'h00);
    check8({2'h0, reg_waddr}, 8'h00);
    check8({7'h0, z_val}, 8'h00);
    rst_b = 1'h1;
    foreach (rows[i]) begin
      issue(rows[i]);
      check8(flags, {2'h0, rows[i].wr[3:1], 3'h1});
      if (rows[i].wr[3])
        check8(acc_wdata, rows[i].res);
      if (rows[i].wr[2]) begin
        check8(reg_wdata, rows[i].res);
        check8({2'h0, reg_waddr}, {2'h0, rows[i].a});
      end
      if (rows[i].wr[1])
        check8({7'h0, z_val}, {7'h0, rows[i].wr[0]});
    end
    // wrap to zero: write lands with the discard, done one cycle later
    issue('{op_inc, 1'h1, 6'h2A, 8'h00, 4'h0, 8'h00, 8'hFF, 8'h00, 4'h0,
            8'h00});
    check8(flags, 8'h16);
    check8(reg_wdata, 8'h00);
    issue('{op_ori, 1'h0, 6'h00, 8'h02, 4'h0, 8'h01, 8'h00, 8'h00, 4'h0,
            8'h00});
    check8(flags, 8'h01);
    issue('{op_inc, 1'h0, 6'h01, 8'h00, 4'h0, 8'h00, 8'hFF, 8'h00, 4'h0,
            8'h00});
    check8(flags, 8'h26);
    check8(acc_wdata, 8'h00);
    idle();
    check8(flags, 8'h01);
    idle();
    clk_en = 1'h0;
    issue('{op_ori, 1'h0, 6'h00, 8'h05, 4'h0, 8'hAA, 8'h00, 8'h00, 4'h0,
            8'h00});
    check8(flags, 8'h00);
    clk_en = 1'h1;
    @(posedge ref_clk);
    #1;
    check8(flags, 8'h29);
    check8(acc_wdata, 8'hAF);
    idle();
    // reset in the no-op slot must clear stall so the next issue is taken
    issue('{op_inc, 1'h1, 6'h07, 8'h00, 4'h0, 8'h00, 8'hFF, 8'h00, 4'h0,
            8'h00});
    check8(flags, 8'h16);
    rst_b = 1'h0;
    #1;
    check8(flags, 8'h00);
    check8(reg_wdata, 8'h00);
    idle();
    rst_b = 1'h1;
    issue('{op_ori, 1'h0, 6'h00, 8'h00, 4'h0, 8'h00, 8'h00, 8'h00, 4'h0,
            8'h00});
    check8(flags, 8'h29);
    check8({7'h0, z_val}, 8'h01);
    idle();
    print_verdict();
  end
endmodule // mcu_incr_skip_or_sfr_read_ops_tb_top
